// >>> hw/keypad_matrix_scanner.v
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.vh"

module keypad_matrix_scanner #(
    parameter SCAN_PERIOD_CYCLES = `KP_SCAN_MS * `KP_CLK_MHZ * 1000,
    parameter RST_MIN_CYCLES     = `KP_RST_MIN_US * `KP_CLK_MHZ
) (
    // Clock and resets
    input  wire        i_core_clk,
    input  wire        i_reset,
    input  wire        i_rst_pin_n,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg         o_pready,
    output reg  [31:0] o_prdata,
    output reg         o_pslverr,
    // Row pins
    input  wire [7:0]  i_row_in,
    output reg  [7:0]  o_row_out,
    output reg  [7:0]  o_row_oe,
    output reg  [7:0]  o_row_pullup,
    // Column pins
    input  wire [9:0]  i_col_in,
    output reg  [9:0]  o_col_out,
    output reg  [9:0]  o_col_oe,
    output reg  [9:0]  o_col_pullup,
    // Host interrupt, open drain
    output reg         o_int_n_out,
    output reg         o_int_n_oe,
    // Serial data pin, open drain
    input  wire        i_sda_pull_low,
    output reg         o_sda_out,
    output reg         o_sda_oe
);

    localparam ST_IDLE  = 3'h0;
    localparam ST_DRIVE = 3'h1;
    localparam ST_PROC  = 3'h2;
    localparam ST_WAIT  = 3'h3;

    // Pin synchronisers.
    reg  [17:0] pin_meta, pin_sync;
    reg         rst_meta, rst_sync;
    wire [7:0]  row_s = pin_sync[7:0];

    // Reset pin qualification.
    reg  [31:0] rst_low_cnt;
    reg         pin_rst;
    wire        rst = i_reset | pin_rst;

    // Registers.
    reg         key_event_irq_enable;
    reg         key_event_flag;
    reg  [7:0]  sel_row;
    reg  [9:0]  sel_col;
    reg  [17:0] general_output_data, general_output_dir;

    // Event store.
    reg  [7:0]  fifo_mem [0:`KP_FIFO_DEPTH-1];
    reg  [3:0]  fifo_rd, fifo_wr, fifo_cnt;
    reg         push;
    reg  [7:0]  push_data;

    // Scanner.
    reg  [2:0]  state;
    reg  [3:0]  col_idx;
    reg  [6:0]  key_idx, key_num;
    reg  [2:0]  settle;
    reg  [31:0] tick_cnt;
    reg  [`KP_KEYS-1:0] cur, prev, held;
    integer     r;

    wire        any_row_low = |(~row_s & sel_row);
    wire        apb_done    = i_psel & i_penable & o_pready;
    wire        apb_wr      = apb_done & i_pwrite;
    wire        apb_rd      = apb_done & ~i_pwrite;
    wire [5:0]  idx         = i_paddr[7:2];
    wire        pop         = apb_rd & (idx == `KP_IDX_EVENT) & (fifo_cnt != 4'h0);
    wire        fifo_full   = (fifo_cnt == `KP_FIFO_DEPTH);

    always @(posedge i_core_clk) begin
        pin_meta <= {i_col_in, i_row_in};
        pin_sync <= pin_meta;
        rst_meta <= i_rst_pin_n;
        rst_sync <= rst_meta;
    end

    // Short low pulses on the reset pin never reach the counter's limit.
    always @(posedge i_core_clk) begin
        if (i_reset | rst_sync) begin
            rst_low_cnt <= 32'h0;
            pin_rst     <= 1'b0;
        end else if (rst_low_cnt >= RST_MIN_CYCLES - 1) begin
            pin_rst     <= 1'b1;
        end else begin
            rst_low_cnt <= rst_low_cnt + 32'h1;
        end
    end

    // APB slave with one wait state; writes and pops act at completion.
    always @(posedge i_core_clk) begin
        if (rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end else if (i_psel & i_penable & ~o_pready) begin
            o_pready  <= 1'b1;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0;
            case (idx)
                `KP_IDX_CFG:        o_prdata[`KP_CFG_IRQ_ENABLE_BIT] <= key_event_irq_enable;
                `KP_IDX_INT_STAT:   o_prdata[`KP_INT_KE_BIT] <= key_event_flag;
                `KP_IDX_EV_COUNT:   o_prdata[3:0] <= fifo_cnt;
                `KP_IDX_EVENT:      o_prdata[7:0] <= (fifo_cnt != 4'h0) ?
                                                     fifo_mem[fifo_rd] : 8'h00;
                `KP_IDX_SEL_ROW:    o_prdata[7:0] <= sel_row;
                `KP_IDX_SEL_COL_LO: o_prdata[7:0] <= sel_col[7:0];
                `KP_IDX_SEL_COL_HI: o_prdata[1:0] <= sel_col[9:8];
                `KP_IDX_GENERAL_OUTPUT_DATA: o_prdata[17:0] <= general_output_data;
                `KP_IDX_GENERAL_OUTPUT_DIR:  o_prdata[17:0] <= general_output_dir;
                `KP_IDX_GENERAL_INPUT:       o_prdata[17:0] <= pin_sync;
                default:            o_pslverr <= 1'b1;
            endcase
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Configuration written by software; all cleared by either reset.
    always @(posedge i_core_clk) begin
        if (rst) begin
            key_event_irq_enable <= `KP_CFG_RESET;
            sel_row              <= `KP_SEL_ROW_RESET;
            sel_col              <= `KP_SEL_COL_RESET;
            general_output_data  <= `KP_GENERAL_OUTPUT_RESET;
            general_output_dir   <= `KP_GENERAL_OUTPUT_RESET;
        end else if (apb_wr) begin
            case (idx)
                `KP_IDX_CFG:        key_event_irq_enable <= i_pwdata[`KP_CFG_IRQ_ENABLE_BIT];
                `KP_IDX_SEL_ROW:    sel_row <= i_pwdata[7:0];
                `KP_IDX_SEL_COL_LO: sel_col[7:0] <= i_pwdata[7:0];
                `KP_IDX_SEL_COL_HI: sel_col[9:8] <= i_pwdata[1:0];
                `KP_IDX_GENERAL_OUTPUT_DATA: general_output_data <= i_pwdata[17:0];
                `KP_IDX_GENERAL_OUTPUT_DIR:  general_output_dir <= i_pwdata[17:0];
                default: ;
            endcase
        end
    end

    // Key-event flag: a new event wins over a clear in the same cycle.
    always @(posedge i_core_clk) begin
        if (rst) begin
            key_event_flag <= 1'b0;
        end else if (push) begin
            key_event_flag <= 1'b1;
        end else if (apb_wr && idx == `KP_IDX_INT_STAT && i_pwdata[`KP_INT_KE_BIT]
                     && fifo_cnt == 4'h0) begin
            key_event_flag <= 1'b0;
        end
    end

    // Event store; new events are dropped while it is full.
    always @(posedge i_core_clk) begin
        if (rst) begin
            fifo_rd  <= 4'h0;
            fifo_wr  <= 4'h0;
            fifo_cnt <= 4'h0;
        end else begin
            if (push && !fifo_full) begin
                fifo_mem[fifo_wr] <= push_data;
                fifo_wr <= (fifo_wr == `KP_FIFO_DEPTH - 1) ? 4'h0 : fifo_wr + 4'h1;
            end
            if (pop) begin
                fifo_rd <= (fifo_rd == `KP_FIFO_DEPTH - 1) ? 4'h0 : fifo_rd + 4'h1;
            end
            if ((push && !fifo_full) && !pop) begin
                fifo_cnt <= fifo_cnt + 4'h1;
            end else if (!(push && !fifo_full) && pop) begin
                fifo_cnt <= fifo_cnt - 4'h1;
            end
        end
    end

    // Scanner: each pass drives one selected column at a time, then
    // walks all keys; a key changes state after two equal samples.
    always @(posedge i_core_clk) begin
        push      <= 1'b0;
        push_data <= 8'h00;
        if (rst) begin
            state    <= ST_IDLE;
            col_idx  <= 4'h0;
            key_idx  <= 7'h0;
            key_num  <= `KP_FIRST_KEY;
            settle   <= 3'h0;
            tick_cnt <= 32'h0;
            cur      <= {`KP_KEYS{1'b0}};
            prev     <= {`KP_KEYS{1'b0}};
            held     <= {`KP_KEYS{1'b0}};
        end else begin
            if (tick_cnt != 32'h0) begin
                tick_cnt <= tick_cnt - 32'h1;
            end
            case (state)
                ST_IDLE: begin
                    if (any_row_low) begin
                        state    <= ST_DRIVE;
                        col_idx  <= 4'h0;
                        settle   <= `KP_SETTLE_CYCLES;
                        tick_cnt <= SCAN_PERIOD_CYCLES - 1;
                        cur      <= {`KP_KEYS{1'b0}};
                    end
                end
                ST_DRIVE: begin
                    if (!sel_col[col_idx] || settle == 3'h0) begin
                        for (r = 0; r < `KP_ROWS; r = r + 1) begin
                            cur[r * `KP_COLS + col_idx] <= sel_col[col_idx] &
                                                          sel_row[r] & ~row_s[r];
                        end
                        settle <= `KP_SETTLE_CYCLES;
                        if (col_idx == `KP_COLS - 1) begin
                            state   <= ST_PROC;
                            key_idx <= 7'h0;
                            col_idx <= 4'h0;
                            key_num <= `KP_FIRST_KEY;
                        end else begin
                            col_idx <= col_idx + 4'h1;
                        end
                    end else begin
                        settle <= settle - 3'h1;
                    end
                end
                ST_PROC: begin
                    if (cur[key_idx] && prev[key_idx] && !held[key_idx]) begin
                        held[key_idx] <= 1'b1;
                        push          <= 1'b1;
                        push_data     <= {1'b1, key_num};
                    end else if (!cur[key_idx] && !prev[key_idx] && held[key_idx]) begin
                        held[key_idx] <= 1'b0;
                        push          <= 1'b1;
                        push_data     <= {1'b0, key_num};
                    end
                    prev[key_idx] <= cur[key_idx];
                    key_idx <= key_idx + 7'h1;
                    key_num <= key_num + 7'h1;
                    if (key_idx == `KP_KEYS - 1) begin
                        state   <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (held == {`KP_KEYS{1'b0}} && prev == {`KP_KEYS{1'b0}}) begin
                        state <= ST_IDLE;
                    end else if (tick_cnt == 32'h0) begin
                        state    <= ST_DRIVE;
                        col_idx  <= 4'h0;
                        settle   <= `KP_SETTLE_CYCLES;
                        tick_cnt <= SCAN_PERIOD_CYCLES - 1;
                        cur      <= {`KP_KEYS{1'b0}};
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pin drivers; matrix columns only ever drive low.
    always @(posedge i_core_clk) begin
        if (rst) begin
            o_row_out    <= 8'h00;
            o_row_oe     <= 8'h00;
            o_row_pullup <= `KP_ROW_PULLUP;
            o_col_out    <= 10'h000;
            o_col_oe     <= 10'h000;
            o_col_pullup <= `KP_COL_PULLUP;
            o_int_n_out  <= 1'b0;
            o_int_n_oe   <= 1'b0;
            o_sda_out    <= 1'b0;
            o_sda_oe     <= 1'b0;
        end else begin
            o_row_pullup <= `KP_ROW_PULLUP;
            o_col_pullup <= `KP_COL_PULLUP;
            o_row_out    <= general_output_data[7:0] & ~sel_row;
            o_row_oe     <= general_output_dir[7:0] & ~sel_row;
            o_col_out    <= general_output_data[17:8] & ~sel_col;
            if (state == ST_DRIVE) begin
                o_col_oe <= (general_output_dir[17:8] & ~sel_col) |
                            (sel_col & (10'h001 << col_idx));
            end else begin
                o_col_oe <= (general_output_dir[17:8] & ~sel_col) | sel_col;
            end
            o_int_n_out  <= 1'b0;
            o_int_n_oe   <= key_event_flag & key_event_irq_enable;
            o_sda_out    <= 1'b0;
            o_sda_oe     <= i_sda_pull_low;
        end
    end

endmodule // keypad_matrix_scanner

`default_nettype wire

// >>> hw/keypad_defs.vh
`ifndef KEYPAD_DEFS_VH
`define KEYPAD_DEFS_VH

// Register indices; the byte address is four times the index.
`define KP_IDX_CFG        6'h01
`define KP_IDX_INT_STAT   6'h02
`define KP_IDX_EV_COUNT   6'h03
`define KP_IDX_EVENT      6'h04
`define KP_IDX_SEL_ROW    6'h1d
`define KP_IDX_SEL_COL_LO 6'h1e
`define KP_IDX_SEL_COL_HI 6'h1f
`define KP_IDX_GENERAL_OUTPUT_DATA 6'h20
`define KP_IDX_GENERAL_OUTPUT_DIR  6'h21
`define KP_IDX_GENERAL_INPUT       6'h22

// Field positions.
`define KP_CFG_IRQ_ENABLE_BIT 0
`define KP_INT_KE_BIT     0
`define KP_EVENT_PRESS    7

// Reset values.
`define KP_SEL_ROW_RESET  8'h00
`define KP_SEL_COL_RESET  10'h000
`define KP_GENERAL_OUTPUT_RESET 18'h00000
`define KP_CFG_RESET      1'b0
`define KP_ROW_PULLUP     8'hff
`define KP_COL_PULLUP     10'h3ff

// Matrix shape, event store depth and key numbering.
`define KP_ROWS           8
`define KP_COLS           10
`define KP_KEYS           80
`define KP_FIFO_DEPTH     10
`define KP_FIRST_KEY      7'h01

// Timing.
`define KP_CLK_MHZ        50
`define KP_SCAN_MS        25
`define KP_RST_MIN_US     50
`define KP_SETTLE_CYCLES  3'h4

`endif

// >>> dv/keypad_matrix_scanner_props.sv
`timescale 1ns/1ps
`default_nettype none
module keypad_props #(
    parameter SCAN_PERIOD_CYCLES = 1250000,
    parameter RST_MIN_CYCLES     = 2500
) (
    input wire logic       i_core_clk,
    input wire logic       i_reset,
    input wire logic       i_rst_pin_n,
    input wire logic       i_psel,
    input wire logic       i_penable,
    input wire logic       o_pready,
    input wire logic [7:0] o_row_pullup,
    input wire logic [9:0] o_col_pullup,
    input wire logic [9:0] o_col_oe,
    input wire logic       o_int_n_out,
    input wire logic       o_int_n_oe,
    input wire logic       i_sda_pull_low,
    input wire logic       o_sda_out,
    input wire logic       o_sda_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Length of the current low period on the reset pin.
    logic [15:0] low_cnt;
    always_ff @(posedge i_core_clk) begin
        if (i_rst_pin_n)
            low_cnt <= 16'h0000;
        else if (low_cnt != 16'hffff)
            low_cnt <= low_cnt + 16'h0001;
    end
    a_int_open_drain: assert property (o_int_n_out == 1'b0)
        else $error("interrupt pin driven high");
    a_sda_open_drain: assert property (o_sda_out == 1'b0)
        else $error("serial data driven high");
    a_sda_pull_low: assert property (i_sda_pull_low |=> o_sda_oe)
        else $error("serial data not pulled low");
    a_sda_release: assert property (!i_sda_pull_low |=> !o_sda_oe)
        else $error("serial data not released");
    a_pullups_on: assert property (o_row_pullup == 8'hff && o_col_pullup == 10'h3ff)
        else $error("pull-up disabled");
    a_pready_pulse: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_pready_cause: assert property (o_pready |-> $past(i_psel) && $past(i_penable))
        else $error("ready without access phase");
    a_reset_quiet: assert property (disable iff (1'b0) i_reset |=> o_col_oe == 10'h000 && !o_int_n_oe)
        else $error("outputs active after reset");
    a_pin_reset_long: assert property (low_cnt == RST_MIN_CYCLES + 8 |-> o_col_oe == 10'h000 && !o_int_n_oe)
        else $error("long reset pin low ignored");
    a_pin_glitch_kept: assert property ((o_int_n_oe && low_cnt <= RST_MIN_CYCLES - 2 && !i_psel
        && !$past(i_psel) && !$past(i_psel, 2)) |=> o_int_n_oe)
        else $error("short reset pin low acted");
    c_int_raised: cover property ($rose(o_int_n_oe));
    c_pin_reset: cover property (low_cnt == RST_MIN_CYCLES + 8);
    c_sda_low: cover property (o_sda_oe);
endmodule // keypad_props
bind keypad_matrix_scanner keypad_props #(
    .SCAN_PERIOD_CYCLES(SCAN_PERIOD_CYCLES),
    .RST_MIN_CYCLES(RST_MIN_CYCLES)
) keypad_props_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_rst_pin_n(i_rst_pin_n), .i_psel(i_psel),
    .i_penable(i_penable), .o_pready(o_pready), .o_row_pullup(o_row_pullup),
    .o_col_pullup(o_col_pullup), .o_col_oe(o_col_oe), .o_int_n_out(o_int_n_out),
    .o_int_n_oe(o_int_n_oe), .i_sda_pull_low(i_sda_pull_low), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe)
);
`default_nettype wire

// >>> dv/keypad_key_model.sv
`timescale 1ns/1ps
`default_nettype none
module keypad_key_model (
    // Pressed keys, index row*10+column
    input  wire logic [79:0] i_keys,
    // Pin drive from the scanner
    input  wire logic [7:0]  i_row_out,
    input  wire logic [7:0]  i_row_oe,
    input  wire logic [9:0]  i_col_out,
    input  wire logic [9:0]  i_col_oe,
    // Resolved pin levels
    output logic      [7:0]  o_row_lvl,
    output logic      [9:0]  o_col_lvl
);
    always_comb begin
        for (int r = 0; r < 8; r++)
            o_row_lvl[r] = i_row_oe[r] ? i_row_out[r] : 1'b1;
        for (int c = 0; c < 10; c++)
            o_col_lvl[c] = i_col_oe[c] ? i_col_out[c] : 1'b1;
        // A closed key lets a line driven low pull its crossing line down.
        for (int r = 0; r < 8; r++)
            for (int c = 0; c < 10; c++)
                if (i_keys[r*10+c]) begin
                    if (i_col_oe[c] && !i_col_out[c])
                        o_row_lvl[r] = 1'b0;
                    if (i_row_oe[r] && !i_row_out[r])
                        o_col_lvl[c] = 1'b0;
                end
    end
endmodule // keypad_key_model
`default_nettype wire

// >>> dv/keypad_matrix_scanner_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "keypad_defs.vh"
module keypad_matrix_scanner_test;
    logic        clk = 0, rst = 1, pin_n = 1, psel = 0, pen = 0, pwr = 0, sda = 0, serr;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [79:0] keys = 0;
    wire  [7:0]  row_in, row_out, row_oe;
    wire  [9:0]  col_in, col_out, col_oe;
    wire  [31:0] prdata;
    wire         pready, pslverr, int_oe;
    wire         int_line = int_oe ? 1'b0 : 1'b1;
    int          err_count = 0, cmp_count = 0;
    int          kr[4] = '{0, 7, 7, 0};
    int          kc[4] = '{0, 9, 0, 9};
    always #10 clk = ~clk;
    keypad_matrix_scanner #(.SCAN_PERIOD_CYCLES(200), .RST_MIN_CYCLES(20)) keypad_matrix_scanner_inst (
        .i_core_clk(clk), .i_reset(rst), .i_rst_pin_n(pin_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
        .o_pslverr(pslverr), .i_row_in(row_in), .o_row_out(row_out), .o_row_oe(row_oe),
        .o_row_pullup(), .i_col_in(col_in), .o_col_out(col_out), .o_col_oe(col_oe),
        .o_col_pullup(), .o_int_n_out(), .o_int_n_oe(int_oe), .i_sda_pull_low(sda),
        .o_sda_out(), .o_sda_oe());
    keypad_key_model keypad_key_model_inst (.i_keys(keys), .i_row_out(row_out), .i_row_oe(row_oe),
        .i_col_out(col_out), .i_col_oe(col_oe), .o_row_lvl(row_in), .o_col_lvl(col_in));
    task end_sim;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic [5:0] i, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk("pready", 1, 32'(pready));
        rdat = prdata;
        serr = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task rd(input string n, input logic [5:0] i, input logic [31:0] e);
        apb(i, 0, 0);
        chk(n, e, rdat);
    endtask
    task wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        wait_clk(20);
        rst <= 0;
        wait_clk(1);
        rd("cfg", `KP_IDX_CFG, 0);
        rd("gen_in", `KP_IDX_GENERAL_INPUT, 32'h3ffff);
        chk("row_oe", 0, 32'(row_oe));
        apb(6'h3f, 0, 0);
        chk("slverr", 1, 32'(serr));
        apb(`KP_IDX_SEL_ROW, 1, 32'h81);
        apb(`KP_IDX_SEL_COL_LO, 1, 32'h01);
        apb(`KP_IDX_SEL_COL_HI, 1, 32'h02);
        apb(`KP_IDX_GENERAL_OUTPUT_DIR, 1, 32'h202);
        apb(`KP_IDX_GENERAL_OUTPUT_DATA, 1, 32'h202);
        apb(`KP_IDX_CFG, 1, 32'h1);
        sda <= 1;
        wait_clk(1);
        sda <= 0;
        wait_clk(3);
        chk("col_oe", 32'h203, 32'(col_oe));
        chk("col_out", 32'h002, 32'(col_out));
        chk("row_oe", 32'h002, 32'(row_oe));
        chk("row_out", 32'h002, 32'(row_out));
        keys[0] <= 1;
        wait_clk(40);
        keys[0] <= 0;
        wait_clk(700);
        rd("count", `KP_IDX_EV_COUNT, 0);
        chk("int_oe", 0, 32'(int_oe));
        for (int i = 0; i < 8; i++) begin
            keys[kr[i%4]*10+kc[i%4]] <= (i < 4);
            wait_clk(700);
            if (i == 0) begin
                rd("flag", `KP_IDX_INT_STAT, 1);
                chk("int_line", 0, 32'(int_line));
            end
        end
        pin_n <= 0;
        wait_clk(10);
        pin_n <= 1;
        wait_clk(5);
        rd("count", `KP_IDX_EV_COUNT, 8);
        apb(`KP_IDX_INT_STAT, 1, 32'h1);
        rd("flag", `KP_IDX_INT_STAT, 1);
        for (int i = 0; i < 8; i++)
            rd("event", `KP_IDX_EVENT, {24'h0, i < 4, 7'(kr[i%4]*10+kc[i%4]+1)});
        rd("event", `KP_IDX_EVENT, 0);
        apb(`KP_IDX_INT_STAT, 1, 32'h1);
        wait_clk(3);
        chk("int_oe", 0, 32'(int_oe));
        chk("col_oe", 32'h203, 32'(col_oe));
        pin_n <= 0;
        wait_clk(30);
        pin_n <= 1;
        wait_clk(5);
        rd("sel", `KP_IDX_SEL_ROW, 0);
        rd("cfg", `KP_IDX_CFG, 0);
        end_sim;
    end
    initial begin
        #1000000;
        err_count++;
        end_sim;
    end
endmodule // keypad_matrix_scanner_test
`default_nettype wire
